// ### core/ccm_clock_mode.sv
// clock generation, warm-up timing and operating-mode sequencing
`timescale 1ns/1ps

module ccm_clock_mode
    import ccm_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              osc_tick,
    input  wire logic              low_speed_clock,
    input  wire logic              lowspeed_available,
    input  wire logic              pll_enable_bit,
    input  wire logic              sysclk_source_select,
    input  wire logic [GEAR_W-1:0] gear_select,
    input  wire logic              periph_source_select,
    input  wire logic [DIV_W-1:0]  prescale_divide_field,
    input  wire logic [1:0]        clock_out_select,
    input  wire logic              warmup_clock_select,
    input  wire logic [2:0]        warmup_time_select,
    input  wire logic              standby_request,
    input  wire logic [2:0]        standby_mode_select,
    input  wire logic              wake_interrupt,
    output logic                   high_speed_clock,
    output logic                   system_clock,
    output logic                   prescaler_base_clock,
    output logic                   core_bus_clock,
    output logic                   core_free_clock,
    output logic                   clock_out_pin,
    output logic                   pll_active,
    output logic                   periph_clock_run,
    output logic                   warmup_started_bit,
    output logic                   warmup_done_flag,
    output logic                   sysclk_source_status,
    output logic [2:0]             mode_status
);
    import ccm_pkg::*;

    // ========================================================
    // state
    ccm_state_e        state_reg;
    ccm_state_e        state_next;
    ccm_state_e        ret_reg;
    logic [PER_W-1:0]  per_cnt_reg;
    logic [PER_W-1:0]  period_reg;
    logic [PER_W-1:0]  phase_reg;
    logic [1:0]        pll_num_reg;
    logic              pll_tick_reg;
    logic [GEAR_W-1:0] gear_reg;
    logic [WUP_W-1:0]  wup_cnt_reg;
    logic              started_reg;
    logic              done_reg;
    logic              fc_reg;
    logic              sys_reg;
    logic              pre_reg;
    logic              bus_reg;
    logic              free_reg;
    logic              cout_reg;
    logic              pll_on_reg;
    logic              prun_reg;
    logic              stat_reg;

    // ========================================================
    // pll: ticks spread evenly over the measured oscillator period;
    // needs at least PLL_MULT reference cycles per oscillator tick
    wire              pll_run;
    wire [PER_W-1:0]  quarter;
    wire              pll_due;

    assign pll_run = pll_enable_bit && (state_reg != ST_SLEEP)
                     && (state_reg != ST_STOP);
    assign quarter = period_reg >> 2;
    assign pll_due = (phase_reg + PER_W'(1) >= quarter)
                     && (pll_num_reg != 2'(PLL_MULT - 1));

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            per_cnt_reg  <= '0;
            period_reg   <= '0;
            phase_reg    <= '0;
            pll_num_reg  <= '0;
            pll_tick_reg <= 1'b0;
        end
        else if (osc_tick)
        begin
            period_reg   <= per_cnt_reg + PER_W'(1);
            per_cnt_reg  <= '0;
            phase_reg    <= '0;
            pll_num_reg  <= '0;
            pll_tick_reg <= pll_run;
        end
        else
        begin
            per_cnt_reg  <= per_cnt_reg + PER_W'(1);
            phase_reg    <= pll_due ? '0 : phase_reg + PER_W'(1);
            pll_num_reg  <= pll_num_reg + 2'(pll_due);
            pll_tick_reg <= pll_run && pll_due;
        end
    end

    // ========================================================
    // clock tree
    wire fc_stopped;
    wire fc_src;
    wire gear_tick;
    wire pre_src;
    wire pre_tick;
    wire sys_tick;
    wire half_tick;
    wire core_run;
    wire cout_sel;

    assign fc_stopped = (state_reg == ST_SLOW) || (state_reg == ST_SLEEP)
                        || (state_reg == ST_STOP);
    assign fc_src   = !fc_stopped
                      && (pll_run ? pll_tick_reg : osc_tick);
    assign pre_src  = periph_source_select ? fc_src : gear_tick;
    assign sys_tick = (state_reg == ST_SLOW) ? low_speed_clock
                    : (state_reg == ST_NORMAL || state_reg == ST_IDLE)
                    ? gear_tick : 1'b0;
    assign core_run = (state_reg == ST_NORMAL) || (state_reg == ST_SLOW);
    assign cout_sel = (clock_out_select == COUT_LOW) ? low_speed_clock
                    : (clock_out_select == COUT_SYS) ? sys_reg
                    : (clock_out_select == COUT_SYS_HALF) ? half_tick
                    : pre_reg;

    ccm_tick_div u_gear_div (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .tick_in  (fc_src),
        .log2_div ({1'b0, gear_reg}),
        .tick_out (gear_tick)
    );

    ccm_tick_div u_pre_div (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .tick_in  (pre_src),
        .log2_div (prescale_divide_field),
        .tick_out (pre_tick)
    );

    ccm_tick_div u_half_div (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .tick_in  (sys_reg),
        .log2_div (HALF_LOG),
        .tick_out (half_tick)
    );

    // gear changes only at a divided tick or while the high-speed clock is stopped, so no short period is produced
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            gear_reg <= GEAR_RESET;
        else if (gear_tick || fc_stopped)
            gear_reg <= gear_select;
    end

    // ========================================================
    // warm-up counter
    wire             wup_tick;
    wire [WUP_W-1:0] wup_last;
    wire             wup_end;
    wire             wake_lp;

    assign wup_tick = warmup_clock_select ? low_speed_clock : osc_tick;
    assign wup_last = WUP_W'((WUP_W+1)'(1) << (WUP_BASE_LOG
                      + int'(warmup_time_select))) - WUP_W'(1);
    assign wup_end  = (state_reg == ST_WARMUP) && wup_tick
                      && (wup_cnt_reg == wup_last);
    assign wake_lp  = wake_interrupt
                      && (state_reg == ST_SLEEP || state_reg == ST_STOP);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            wup_cnt_reg <= '0;
            started_reg <= 1'b0;
            done_reg    <= 1'b0;
        end
        else if (wake_lp)
        begin
            wup_cnt_reg <= '0;
            started_reg <= 1'b1;
            done_reg    <= 1'b0;
        end
        else if (wup_end)
        begin
            started_reg <= 1'b0;
            done_reg    <= 1'b1;
        end
        else if (state_reg == ST_WARMUP && wup_tick)
            wup_cnt_reg <= wup_cnt_reg + WUP_W'(1);
    end

    // ========================================================
    // mode sequencing
    wire stby_ok;

    assign stby_ok = (standby_mode_select == STBY_IDLE)
                     || (standby_mode_select == STBY_STOP)
                     || ((standby_mode_select == STBY_SLEEP)
                         && lowspeed_available);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_NORMAL, ST_SLOW:
            begin
                if (standby_request && stby_ok)
                    state_next = (standby_mode_select == STBY_IDLE) ? ST_IDLE
                               : (standby_mode_select == STBY_SLEEP) ? ST_SLEEP
                               : ST_STOP;
                else if (state_reg == ST_NORMAL && sysclk_source_select
                         && lowspeed_available && low_speed_clock)
                    state_next = ST_SLOW;
                else if (state_reg == ST_SLOW && !sysclk_source_select
                         && osc_tick)
                    state_next = ST_NORMAL;
            end
            ST_IDLE:
                if (wake_interrupt)
                    state_next = ret_reg;
            ST_SLEEP, ST_STOP:
                if (wake_interrupt)
                    state_next = ST_WARMUP;
            ST_WARMUP:
                if (wup_end)
                    state_next = ret_reg;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_reg <= ST_NORMAL;
            ret_reg   <= ST_NORMAL;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == ST_NORMAL || state_reg == ST_SLOW)
                ret_reg <= state_reg;
        end
    end

    // ========================================================
    // registered outputs
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            fc_reg     <= 1'b0;
            sys_reg    <= 1'b0;
            pre_reg    <= 1'b0;
            bus_reg    <= 1'b0;
            free_reg   <= 1'b0;
            cout_reg   <= 1'b0;
            pll_on_reg <= 1'b0;
            prun_reg   <= 1'b1;
            stat_reg   <= 1'b0;
        end
        else
        begin
            fc_reg     <= fc_src;
            sys_reg    <= sys_tick;
            pre_reg    <= pre_tick;
            bus_reg    <= sys_tick && core_run;
            free_reg   <= sys_tick && core_run;
            cout_reg   <= cout_sel;
            pll_on_reg <= pll_run;
            prun_reg   <= (state_reg == ST_NORMAL) || (state_reg == ST_IDLE);
            stat_reg   <= (state_next == ST_SLOW);
        end
    end

    assign high_speed_clock     = fc_reg;
    assign system_clock         = sys_reg;
    assign prescaler_base_clock = pre_reg;
    assign core_bus_clock       = bus_reg;
    assign core_free_clock      = free_reg;
    assign clock_out_pin        = cout_reg;
    assign pll_active           = pll_on_reg;
    assign periph_clock_run     = prun_reg;
    assign warmup_started_bit   = started_reg;
    assign warmup_done_flag     = done_reg;
    assign sysclk_source_status = stat_reg;
    assign mode_status          = state_reg;

    // ========================================================
    // checks
    a_reset_normal: assert property (@(posedge ref_clk)
        !resetn |=> state_reg == ST_NORMAL && !pll_active)
        else $error("reset did not give normal mode with pll off");

    a_pll_stop_lp: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_reg == ST_SLEEP || state_reg == ST_STOP) |=> !pll_active)
        else $error("pll running in sleep or stop");

    a_warmup_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        wake_lp |=> state_reg == ST_WARMUP && warmup_started_bit && !warmup_done_flag)
        else $error("warm-up did not start on wake");

    a_warmup_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_reg == ST_WARMUP |=> !system_clock && !core_bus_clock)
        else $error("clock released during warm-up");

    a_warmup_end: assert property (@(posedge ref_clk) disable iff (!resetn)
        wup_end |=> warmup_done_flag && !warmup_started_bit && state_reg == $past(ret_reg))
        else $error("warm-up end not reported");

    a_no_slow_ls: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!lowspeed_available && state_reg == ST_NORMAL) |=> state_reg != ST_SLOW
        && state_reg != ST_SLEEP)
        else $error("slow or sleep entered without low-speed clock");

    a_core_halt: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_reg == ST_IDLE || state_reg == ST_SLEEP || state_reg == ST_STOP)
        |=> !core_bus_clock && !core_free_clock)
        else $error("core clock running in low-power mode");

    a_slow_fc_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_reg == ST_SLOW |=> !high_speed_clock)
        else $error("high-speed clock running in slow mode");

    a_status_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(state_reg == ST_SLOW) |-> sysclk_source_status ##1 !high_speed_clock)
        else $error("source status not following switch");

endmodule

// ### core/ccm_pkg.sv
// shared constants and types for the clock and mode controller
package ccm_pkg;

    // ========================================================
    // operating modes
    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_SLOW,
        ST_IDLE,
        ST_SLEEP,
        ST_STOP,
        ST_WARMUP
    } ccm_state_e;

    // ========================================================
    // standby mode codes on standby_mode_select
    localparam logic [2:0] STBY_STOP  = 3'h1;
    localparam logic [2:0] STBY_SLEEP = 3'h2;
    localparam logic [2:0] STBY_IDLE  = 3'h3;

    // ========================================================
    // field widths and reset values
    localparam int         GEAR_W        = 2;
    localparam int         DIV_W         = 3;
    localparam logic [1:0] GEAR_RESET    = 2'h0;
    localparam logic [2:0] PRESCALE_ONE  = 3'h0;
    localparam logic [2:0] HALF_LOG      = 3'h1;
    localparam int         PLL_MULT      = 4;
    localparam int         PER_W         = 8;
    localparam int         WUP_W         = 16;
    localparam int         WUP_BASE_LOG  = 8;

    // ========================================================
    // clock output selector codes
    localparam logic [1:0] COUT_LOW      = 2'h0;
    localparam logic [1:0] COUT_SYS      = 2'h1;
    localparam logic [1:0] COUT_SYS_HALF = 2'h2;
    localparam logic [1:0] COUT_PRESCALE = 2'h3;

endpackage

// ### core/ccm_tick_div.sv
// power-of-two divider of a one-cycle enable pulse
`timescale 1ns/1ps
module ccm_tick_div
    import ccm_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             tick_in,
    input  wire logic [DIV_W-1:0] log2_div,
    output logic                  tick_out
);
    import ccm_pkg::*;

    localparam int CNT_W = (1 << DIV_W) - 1;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             tick_reg;
    wire  [CNT_W-1:0] mask;
    wire              hit;

    assign mask     = CNT_W'((CNT_W+1)'(1) << log2_div) - CNT_W'(1);
    assign hit      = tick_in && ((cnt_reg & mask) == mask);
    assign cnt_next = tick_in ? cnt_reg + CNT_W'(1) : cnt_reg;
    assign tick_out = tick_reg;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            tick_reg <= hit;
        end
    end

endmodule

// ### testbench/ccm_osc_model.sv
// oscillator model: high-speed and low-speed tick sources feeding the controller
`timescale 1ns/1ps
module ccm_osc_model
#(
    parameter int OSC_PER = 8,
    parameter int LOW_PER = 40
)
(
    input  wire logic ref_clk,
    output logic      osc_tick,
    output logic      low_speed_clock
);
    // ========================================================
    // free-running counters
    // crystals keep swinging through a core reset, so no reset here
    int osc_cnt_reg = 0;
    int low_cnt_reg = 0;

    always_ff @(posedge ref_clk)
    begin
        osc_cnt_reg <= (osc_cnt_reg >= OSC_PER - 1) ? 0 : osc_cnt_reg + 1;
        low_cnt_reg <= (low_cnt_reg >= LOW_PER - 1) ? 0 : low_cnt_reg + 1;
    end

    // one-cycle pulses, as the controller expects its tick inputs
    assign osc_tick        = (osc_cnt_reg == OSC_PER - 1);
    assign low_speed_clock = (low_cnt_reg == LOW_PER - 1);
endmodule

// ### testbench/ccm_clock_mode_tb_top.sv
// self-checking bench for the clock and mode controller
`timescale 1ns/1ps
module ccm_clock_mode_tb_top;
    import ccm_pkg::*;

    typedef struct {
        logic       pll;
        logic [1:0] gear;
        logic       psrc;
        logic [2:0] pdiv;
        logic [1:0] cout;
        int         fc;
        int         sys;
        int         pre;
        int         co;
    } ccm_row_s;

    // 640 cycles hold 80 oscillator periods and 16 low-speed periods
    localparam int WIN = 640;

    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       osc_tick, low_speed_clock;
    logic       lowspeed_available = 1'b1, pll_enable_bit = 1'b0;
    logic       sysclk_source_select = 1'b0, periph_source_select = 1'b0;
    logic [1:0] gear_select = 2'h0, clock_out_select = 2'h1;
    logic [2:0] prescale_divide_field = 3'h0, warmup_time_select = 3'h0;
    logic [2:0] standby_mode_select = 3'h0;
    logic       warmup_clock_select = 1'b0, standby_request = 1'b0, wake_interrupt = 1'b0;
    logic       high_speed_clock, system_clock, prescaler_base_clock, core_bus_clock;
    logic       core_free_clock, clock_out_pin, pll_active, periph_clock_run;
    logic       warmup_started_bit, warmup_done_flag, sysclk_source_status;
    logic [2:0] mode_status;
    logic [5:0] pulses;
    logic       counting = 1'b0;
    int         cnt [6];
    int         miscompares = 0;
    int         num_checks = 0;
    ccm_row_s   rows [6];

    always #2.5 ref_clk = ~ref_clk;

    ccm_osc_model i_ccm_osc_model (.ref_clk(ref_clk), .osc_tick(osc_tick),
        .low_speed_clock(low_speed_clock));

    ccm_clock_mode i_ccm_clock_mode (.ref_clk(ref_clk), .resetn(resetn), .osc_tick(osc_tick),
        .low_speed_clock(low_speed_clock), .lowspeed_available(lowspeed_available),
        .pll_enable_bit(pll_enable_bit), .sysclk_source_select(sysclk_source_select),
        .gear_select(gear_select), .periph_source_select(periph_source_select),
        .prescale_divide_field(prescale_divide_field), .clock_out_select(clock_out_select),
        .warmup_clock_select(warmup_clock_select), .warmup_time_select(warmup_time_select),
        .standby_request(standby_request), .standby_mode_select(standby_mode_select),
        .wake_interrupt(wake_interrupt), .high_speed_clock(high_speed_clock),
        .system_clock(system_clock), .prescaler_base_clock(prescaler_base_clock),
        .core_bus_clock(core_bus_clock), .core_free_clock(core_free_clock),
        .clock_out_pin(clock_out_pin), .pll_active(pll_active),
        .periph_clock_run(periph_clock_run), .warmup_started_bit(warmup_started_bit),
        .warmup_done_flag(warmup_done_flag), .sysclk_source_status(sysclk_source_status),
        .mode_status(mode_status));

    // ========================================================
    // pulse counters
    assign pulses = {high_speed_clock, system_clock, prescaler_base_clock, clock_out_pin,
                     core_bus_clock, core_free_clock};

    always @(posedge ref_clk)
        if (counting)
            for (int i = 0; i < 6; i++)
                cnt[i] <= cnt[i] + ((pulses[5-i] === 1'b1) ? 1 : 0);

    // ========================================================
    // compare and sequencing tasks
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_bit(input string name, input logic exp, input logic seen);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic check_mode(input logic [2:0] exp);
        num_checks++;
        if (mode_status !== exp)
        begin
            miscompares++;
            $display("Error mode_status expected %0d seen %0d", exp, mode_status);
        end
    endtask

    // window edges cut a pulse train anywhere, hence the tolerance
    task automatic check_count(input string name, input int exp, input int seen, input int tol);
        num_checks++;
        if (seen < exp - tol || seen > exp + tol)
        begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    task automatic measure(input int len);
        for (int i = 0; i < 6; i++)
            cnt[i] = 0;
        counting = 1'b1;
        repeat (len) @(negedge ref_clk);
        counting = 1'b0;
    endtask

    task automatic pulse_standby(input logic [2:0] code);
        @(negedge ref_clk);
        standby_mode_select = code;
        standby_request = 1'b1;
        @(negedge ref_clk);
        standby_request = 1'b0;
    endtask

    task automatic pulse_wake();
        @(negedge ref_clk);
        wake_interrupt = 1'b1;
        @(negedge ref_clk);
        wake_interrupt = 1'b0;
    endtask

    task automatic wait_mode(input logic [2:0] exp, input int bound, output int waited);
        waited = 0;
        while (mode_status !== exp && waited < bound)
        begin
            @(negedge ref_clk);
            waited++;
        end
        if (mode_status !== exp)
        begin
            miscompares++;
            $display("Error wait for mode %0d timed out, seen %0d", exp, mode_status);
            print_verdict();
        end
    endtask

    // ========================================================
    // main sequence
    initial
    begin
        int w;
        rows[0] = '{1'b0, 2'h0, 1'b0, 3'h0, 2'h1, 80, 80, 80, 80};
        rows[1] = '{1'b1, 2'h0, 1'b0, 3'h0, 2'h2, 320, 320, 320, 160};
        rows[2] = '{1'b1, 2'h1, 1'b0, 3'h1, 2'h3, 320, 160, 80, 80};
        rows[3] = '{1'b1, 2'h2, 1'b1, 3'h2, 2'h0, 320, 80, 80, 16};
        rows[4] = '{1'b0, 2'h3, 1'b0, 3'h0, 2'h1, 80, 10, 10, 10};
        rows[5] = '{1'b1, 2'h3, 1'b1, 3'h5, 2'h3, 320, 40, 10, 10};
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        check_mode(ST_NORMAL);
        check_bit("pll_active", 1'b0, pll_active);
        check_bit("warmup_done_flag", 1'b0, warmup_done_flag);
        check_bit("sysclk_source_status", 1'b0, sysclk_source_status);
        check_bit("periph_clock_run", 1'b1, periph_clock_run);
        $display("test reset done");
        for (int r = 0; r < 6; r++)
        begin
            pll_enable_bit = rows[r].pll;
            gear_select = rows[r].gear;
            periph_source_select = rows[r].psrc;
            prescale_divide_field = rows[r].pdiv;
            clock_out_select = rows[r].cout;
            repeat (100) @(negedge ref_clk);
            measure(WIN);
            check_count("high_speed_clock", rows[r].fc, cnt[0], 1);
            check_count("system_clock", rows[r].sys, cnt[1], 1);
            check_count("prescaler_base_clock", rows[r].pre, cnt[2], 1);
            check_count("clock_out_pin", rows[r].co, cnt[3], 1);
            check_count("core_bus_clock", rows[r].sys, cnt[4], 1);
            check_count("core_free_clock", rows[r].sys, cnt[5], 1);
            $display("test row %0d done", r);
        end
        gear_select = 2'h0;
        clock_out_select = 2'h1;
        // low-speed clock unavailable: switch and sleep are refused
        lowspeed_available = 1'b0;
        sysclk_source_select = 1'b1;
        repeat (200) @(negedge ref_clk);
        check_bit("sysclk_source_status", 1'b0, sysclk_source_status);
        pulse_standby(STBY_SLEEP);
        repeat (3) @(negedge ref_clk);
        check_mode(ST_NORMAL);
        pulse_standby(3'h0);
        repeat (3) @(negedge ref_clk);
        check_mode(ST_NORMAL);
        sysclk_source_select = 1'b0;
        lowspeed_available = 1'b1;
        $display("test refusals done");
        // stop with oscillator-counted warm-up of 2^9 ticks
        warmup_clock_select = 1'b0;
        warmup_time_select = 3'h1;
        pulse_standby(STBY_STOP);
        repeat (3) @(negedge ref_clk);
        check_mode(ST_STOP);
        check_bit("pll_active", 1'b0, pll_active);
        check_bit("periph_clock_run", 1'b0, periph_clock_run);
        measure(WIN);
        check_count("system_clock", 0, cnt[1], 0);
        check_count("core_bus_clock", 0, cnt[4], 0);
        check_count("core_free_clock", 0, cnt[5], 0);
        pulse_wake();
        check_mode(ST_WARMUP);
        check_bit("warmup_started_bit", 1'b1, warmup_started_bit);
        check_bit("warmup_done_flag", 1'b0, warmup_done_flag);
        for (int i = 0; i < 6; i++)
            cnt[i] = 0;
        counting = 1'b1;
        wait_mode(ST_NORMAL, 6000, w);
        counting = 1'b0;
        check_count("system_clock", 0, cnt[1], 0);
        check_count("warmup cycles", 4096, w, 16);
        check_bit("warmup_started_bit", 1'b0, warmup_started_bit);
        check_bit("warmup_done_flag", 1'b1, warmup_done_flag);
        $display("test stop done");
        // source switch to the low-speed clock at its next tick and back at the next oscillator tick
        sysclk_source_select = 1'b1;
        wait_mode(ST_SLOW, 200, w);
        check_bit("sysclk_source_status", 1'b1, sysclk_source_status);
        gear_select = 2'h3;
        repeat (100) @(negedge ref_clk);
        check_bit("periph_clock_run", 1'b0, periph_clock_run);
        measure(WIN);
        check_count("high_speed_clock", 0, cnt[0], 0);
        check_count("system_clock", 16, cnt[1], 1);
        gear_select = 2'h0;
        sysclk_source_select = 1'b0;
        wait_mode(ST_NORMAL, 200, w);
        check_bit("sysclk_source_status", 1'b0, sysclk_source_status);
        $display("test slow done");
        // sleep with low-speed-counted warm-up of 2^8 ticks
        warmup_clock_select = 1'b1;
        warmup_time_select = 3'h0;
        pulse_standby(STBY_SLEEP);
        repeat (3) @(negedge ref_clk);
        check_mode(ST_SLEEP);
        check_bit("pll_active", 1'b0, pll_active);
        pulse_wake();
        wait_mode(ST_NORMAL, 12000, w);
        check_count("warmup cycles", 10240, w, 80);
        $display("test sleep done");
        pulse_standby(STBY_IDLE);
        repeat (3) @(negedge ref_clk);
        check_mode(ST_IDLE);
        check_bit("periph_clock_run", 1'b1, periph_clock_run);
        measure(WIN);
        check_count("core_bus_clock", 0, cnt[4], 0);
        check_count("high_speed_clock", 320, cnt[0], 1);
        pulse_wake();
        repeat (2) @(negedge ref_clk);
        check_mode(ST_NORMAL);
        $display("test idle done");
        // reset in the middle of a warm-up
        pulse_standby(STBY_STOP);
        pulse_wake();
        repeat (100) @(negedge ref_clk);
        resetn = 1'b0;
        pll_enable_bit = 1'b0;
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        check_mode(ST_NORMAL);
        check_bit("warmup_started_bit", 1'b0, warmup_started_bit);
        check_bit("pll_active", 1'b0, pll_active);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
